// ===== pkg/aesf_pkg.sv
// Constants for the accelerometer event status flag block.
// Assumes a host register port decodes addresses and pulses read strobes.
//
// Overview of operation
// - Data-ready sets when a fresh XYZ and temperature result set arrives.
// - Data-ready clears on any read of magnitude or axis output registers.
// - Buffer mode above zero forces data-ready to zero.
// - Boot pin low: output read clears data-ready flag and its interrupt.
// - Boot pin high: data-ready interrupt is a self-clearing pulse of 5 ms.
// - Entering standby cuts a running data-ready pulse short at once.
// - Overrun sets when new results land before previous set was read.
// - No overrun if any axis output register was read before new results.
// - Any read of the interrupt status register clears overrun.
// - Buffer mode above zero holds overrun at zero.
// - Buffer event flag is OR of watermark, overflow and gate error.
// - Buffer event flag may be active only when buffer mode above zero.
// - In triggered buffer mode watermark is excluded from buffer event.
// - Buffer full sets buffer event and may raise a routed interrupt pin.
// - Outside flag mirrors outside event; latched clears on source read.
// - Within flag mirrors within event; latched clears on source read.
// - Writes act only in standby except active, soft reset, flush bits.
// - External trigger mode ignores host changes to the active bit.
// - Endian select picks little right or big left; little is default.
// - Standby to active or trigger marks output buffer contents invalid.
// - Volatile event sources reset when leaving standby for active modes.
// - Boot-done sets on reset and after boot, holds until soft reset or hibernate exit.
// - Orientation change sets on new orientation, clears on status read.
// - Auto-sleep flag sets on any wake/sleep change, clears on mode read.

package aesf_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h01;

  // ==========================================================
  // Bit positions in the status byte
  localparam int BIT_DRDY = 7;
  localparam int BIT_OVF = 6;
  localparam int BIT_BUF = 5;
  localparam int BIT_OT = 4;
  localparam int BIT_WT = 3;
  localparam int BIT_ORIENT = 2;
  localparam int BIT_ASLP = 1;
  localparam int BIT_BOOT = 0;

  // ==========================================================
  // Buffer mode codes
  localparam logic [1:0] BUF_MODE_OFF = 2'h0;
  localparam logic [1:0] BUF_MODE_TRIG = 2'h3;

  // ==========================================================
  // Data-ready pulse width on the boot pin high strap
  localparam int CLK_HZ = 100_000_000;
  localparam int PULSE_US = 5000;
  localparam int PULSE_CYCLES = CLK_HZ / 1_000_000 * PULSE_US;

  // Operating modes
  typedef enum logic [1:0] {
    AESF_STANDBY,
    AESF_ACTIVE,
    AESF_EXTERNAL_TRIGGER_MODE
  } aesf_mode_t;

endpackage

// ===== design/aesf_flags.sv
// Event status flag aggregation and interrupt pins of the accelerometer.
// Assumes engines and host port on clk give one-cycle pulses and levels.
`timescale 1ns/1ps

module aesf_flags #(
  parameter int PULSE_LEN = aesf_pkg::PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  // Strap, asynchronous
  input wire logic boot_mode_pin,
  // Host register access strobes
  input wire logic host_wr,
  input wire logic [7:0] host_wr_addr,
  input wire logic [7:0] host_wr_data,
  input wire logic wr_active_bit,
  input wire logic wr_active_val,
  input wire logic wr_soft_reset,
  input wire logic wr_buf_flush,
  input wire logic rd_status,
  input wire logic rd_vector_magnitude_out,
  input wire logic rd_axis_out,
  input wire logic rd_outside_event_source,
  input wire logic rd_within_event_source,
  input wire logic rd_orientation_status_reg,
  input wire logic rd_system_mode_reg,
  // Configuration held by the register file
  input wire logic [1:0] buf_mode,
  input wire logic outside_latch_enable,
  input wire logic within_latch_enable,
  input wire logic endian_select_in,
  input wire logic [7:0] int_enable,
  input wire logic [7:0] int_route_two,
  input wire logic external_trigger_mode,
  input wire logic hibernate_exit,
  // Engine events
  input wire logic new_result,
  input wire logic buffer_watermark_flag,
  input wire logic buffer_overflow_flag,
  input wire logic buffer_gate_error,
  input wire logic outside_event_active,
  input wire logic within_event_active,
  input wire logic new_orientation,
  input wire logic sleep_wake_change,
  input wire logic boot_finished,
  // Outputs
  output logic [7:0] interrupt_event_status,
  output logic active_bit,
  output logic soft_reset_pulse,
  output logic buf_flush_pulse,
  output logic cfg_write_en,
  output logic endian_select,
  output logic buffer_invalidate,
  output logic volatile_reset,
  output logic interrupt_pin_one,
  output logic interrupt_pin_two
);

  initial begin
    if (PULSE_LEN < 1) begin
      $error("PULSE_LEN must be at least one cycle");
    end
  end

  // ==========================================================
  // Strap synchroniser
  logic boot_pin_meta;
  logic boot_pin_sync;

  always_ff @(posedge clk) begin
    boot_pin_meta <= boot_mode_pin;
    boot_pin_sync <= boot_pin_meta;
  end

  // ==========================================================
  // Operating mode
  aesf_pkg::aesf_mode_t mode;
  aesf_pkg::aesf_mode_t next_mode;
  logic leave_standby;
  logic enter_standby;
  logic output_read;
  logic buf_on;
  logic trig_mode;

  // Trigger mode locks the active bit; other modes follow the host
  always_comb begin
    next_mode = mode;
    unique case (mode)
      aesf_pkg::AESF_STANDBY: begin
        if (wr_active_bit && wr_active_val) begin
          next_mode = external_trigger_mode ? aesf_pkg::AESF_EXTERNAL_TRIGGER_MODE :
                                              aesf_pkg::AESF_ACTIVE;
        end
      end
      aesf_pkg::AESF_ACTIVE: begin
        if (wr_active_bit && !wr_active_val) begin
          next_mode = aesf_pkg::AESF_STANDBY;
        end
      end
      aesf_pkg::AESF_EXTERNAL_TRIGGER_MODE: begin
        next_mode = aesf_pkg::AESF_EXTERNAL_TRIGGER_MODE;
      end
      default: next_mode = aesf_pkg::AESF_STANDBY;
    endcase
    if (wr_soft_reset) begin
      next_mode = aesf_pkg::AESF_STANDBY;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= aesf_pkg::AESF_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  assign leave_standby = (mode == aesf_pkg::AESF_STANDBY) &&
                         (next_mode != aesf_pkg::AESF_STANDBY);
  assign enter_standby = (mode != aesf_pkg::AESF_STANDBY) &&
                         (next_mode == aesf_pkg::AESF_STANDBY);
  assign output_read = rd_vector_magnitude_out || rd_axis_out;
  assign buf_on = (buf_mode != aesf_pkg::BUF_MODE_OFF);
  assign trig_mode = (buf_mode == aesf_pkg::BUF_MODE_TRIG);
  assign active_bit = (mode != aesf_pkg::AESF_STANDBY);

  // Exempt bits pass in any mode; the rest only in standby
  assign soft_reset_pulse = wr_soft_reset;
  assign buf_flush_pulse = wr_buf_flush;
  assign cfg_write_en = host_wr && (mode == aesf_pkg::AESF_STANDBY);
  assign buffer_invalidate = leave_standby;
  assign volatile_reset = leave_standby;

  // ==========================================================
  // Endian select, captured only in standby, little-endian default
  always_ff @(posedge clk) begin
    if (srst || wr_soft_reset) begin
      endian_select <= 1'b0;
    end else if (cfg_write_en &&
                 host_wr_addr != aesf_pkg::STATUS_OFFSET) begin
      endian_select <= endian_select_in;
    end
  end

  // ==========================================================
  // Data-ready and overrun
  logic drdy;
  logic ovf;
  logic set_unread;

  // New data wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (srst || leave_standby || buf_on) begin
      drdy <= 1'b0;
    end else if (new_result) begin
      drdy <= 1'b1;
    end else if (output_read) begin
      drdy <= 1'b0;
    end
  end

  // Tracks whether the current set has seen any axis read
  always_ff @(posedge clk) begin
    if (srst || leave_standby) begin
      set_unread <= 1'b0;
    end else if (new_result) begin
      set_unread <= 1'b1;
    end else if (rd_axis_out) begin
      set_unread <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || leave_standby || buf_on) begin
      ovf <= 1'b0;
    end else if (new_result && set_unread && !rd_axis_out) begin
      ovf <= 1'b1;
    end else if (rd_status) begin
      ovf <= 1'b0;
    end
  end

  // ==========================================================
  // Data-ready pulse for the boot pin high strap
  logic [$clog2(PULSE_LEN + 1)-1:0] pulse_cnt;
  logic drdy_pulse;

  always_ff @(posedge clk) begin
    if (srst || enter_standby || !boot_pin_sync || buf_on) begin
      pulse_cnt <= '0;
    end else if (new_result) begin
      pulse_cnt <= ($clog2(PULSE_LEN + 1))'(PULSE_LEN);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  assign drdy_pulse = (pulse_cnt != '0);

  // ==========================================================
  // Buffer event; watermark dropped in triggered mode
  logic buf_evt;

  assign buf_evt = buf_on &&
                   ((buffer_watermark_flag && !trig_mode) ||
                    buffer_overflow_flag ||
                    buffer_gate_error);

  // ==========================================================
  // Threshold copies; latched copies hold until source read
  logic ot_flag;
  logic wt_flag;

  always_ff @(posedge clk) begin
    if (srst || leave_standby) begin
      ot_flag <= 1'b0;
    end else if (outside_event_active) begin
      ot_flag <= 1'b1;
    end else if (!outside_latch_enable || rd_outside_event_source) begin
      ot_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || leave_standby) begin
      wt_flag <= 1'b0;
    end else if (within_event_active) begin
      wt_flag <= 1'b1;
    end else if (!within_latch_enable || rd_within_event_source) begin
      wt_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Orientation, auto-sleep and boot flags
  logic orient_flag;
  logic aslp_flag;
  logic boot_flag;

  always_ff @(posedge clk) begin
    if (srst) begin
      orient_flag <= 1'b0;
    end else if (new_orientation) begin
      orient_flag <= 1'b1;
    end else if (rd_orientation_status_reg) begin
      orient_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aslp_flag <= 1'b0;
    end else if (sleep_wake_change) begin
      aslp_flag <= 1'b1;
    end else if (rd_system_mode_reg) begin
      aslp_flag <= 1'b0;
    end
  end

  // Boot is complete once reset ends unless the engine is rebooting
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_flag <= aesf_pkg::STATUS_RESET[aesf_pkg::BIT_BOOT];
    end else if (wr_soft_reset || hibernate_exit) begin
      boot_flag <= 1'b0;
    end else if (boot_finished) begin
      boot_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Status byte, all flags sampled together
  logic [7:0] flags;

  always_comb begin
    flags = 8'h00;
    flags[aesf_pkg::BIT_DRDY] = drdy;
    flags[aesf_pkg::BIT_OVF] = ovf;
    flags[aesf_pkg::BIT_BUF] = buf_evt;
    flags[aesf_pkg::BIT_OT] = ot_flag;
    flags[aesf_pkg::BIT_WT] = wt_flag;
    flags[aesf_pkg::BIT_ORIENT] = orient_flag;
    flags[aesf_pkg::BIT_ASLP] = aslp_flag;
    flags[aesf_pkg::BIT_BOOT] = boot_flag;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_event_status <= aesf_pkg::STATUS_RESET;
    end else begin
      interrupt_event_status <= flags;
    end
  end

  // ==========================================================
  // Interrupt pins; pulse replaces the data-ready level on strap high
  logic [7:0] pin_src;

  always_comb begin
    pin_src = flags & int_enable;
    pin_src[aesf_pkg::BIT_DRDY] = int_enable[aesf_pkg::BIT_DRDY] &&
      (boot_pin_sync ? drdy_pulse : drdy);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_pin_one <= 1'b0;
      interrupt_pin_two <= 1'b0;
    end else begin
      interrupt_pin_one <= |(pin_src & ~int_route_two);
      interrupt_pin_two <= |(pin_src & int_route_two);
    end
  end

endmodule

// ===== bench/aesf_flags_monitor.sv
// Concurrent checks on the event status flag block's ports.
// Assumes registered flags reach the status byte two edges after inputs,
// the combinational buffer event one edge after.
`timescale 1ns/1ps

module aesf_flags_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic new_result,
  input wire logic rd_axis_out,
  input wire logic rd_vector_magnitude_out,
  input wire logic rd_status,
  input wire logic [1:0] buf_mode,
  input wire logic buffer_watermark_flag,
  input wire logic buffer_overflow_flag,
  input wire logic buffer_gate_error,
  input wire logic within_event_active,
  input wire logic host_wr,
  input wire logic cfg_write_en,
  input wire logic active_bit,
  input wire logic buffer_invalidate,
  input wire logic volatile_reset,
  input wire logic [7:0] interrupt_event_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic buf_d1;

  // ==========================================================
  // Expected buffer event, delayed to the status byte's latency
  always_ff @(posedge clk) begin
    buf_d1 <= buf_mode != 2'h0 && (buffer_overflow_flag || buffer_gate_error
      || (buffer_watermark_flag && buf_mode != 2'h3));
  end

  // ==========================================================
  // Properties
  property p_drdy_set;
    new_result && buf_mode == 2'h0 ##1 buf_mode == 2'h0
      |=> interrupt_event_status[7];
  endproperty
  a_drdy_set: assert property (p_drdy_set) else $error("drdy not set");
  property p_drdy_clr;
    (rd_axis_out || rd_vector_magnitude_out) && !new_result
      |-> ##2 !interrupt_event_status[7];
  endproperty
  a_drdy_clr: assert property (p_drdy_clr) else $error("drdy kept");
  property p_buf_hold;
    buf_mode != 2'h0 ##1 buf_mode != 2'h0
      |=> interrupt_event_status[7:6] == 2'h0;
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("held bits set");
  property p_ovf_clr;
    rd_status && !new_result |-> ##2 !interrupt_event_status[6];
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overrun kept");
  property p_buf_event;
    interrupt_event_status[5] == buf_d1;
  endproperty
  a_buf_event: assert property (p_buf_event) else $error("buf bit bad");
  property p_wt_set;
    within_event_active |-> ##2 interrupt_event_status[3];
  endproperty
  a_wt_set: assert property (p_wt_set) else $error("within not set");
  property p_cfg_gate;
    cfg_write_en |-> host_wr && !active_bit;
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("write leaked");
  property p_leave_standby;
    buffer_invalidate || volatile_reset
      |-> buffer_invalidate && volatile_reset && !active_bit;
  endproperty
  a_leave_standby: assert property (p_leave_standby) else $error("bad exit");

  // Main scenarios reached
  c_drdy: cover property (new_result ##2 interrupt_event_status[7]);
  c_exit: cover property (buffer_invalidate);
  c_ovf: cover property (interrupt_event_status[6] ##1 rd_status);
endmodule

bind aesf_flags aesf_flags_monitor u_mon (.*);

// ===== bench/aesf_host_model.sv
// Host processor model issuing register read strobes and writes.
// Assumes the bench maps rd bits onto the block's read strobe ports.
`timescale 1ns/1ps

module aesf_host_model (
  input wire logic clk,
  output logic [6:0] rd,
  output logic host_wr,
  output logic wr_active_bit,
  output logic wr_active_val
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    rd = 7'h00;
    host_wr = 1'b0;
    wr_active_bit = 1'b0;
    wr_active_val = 1'b0;
  end

  // One-cycle read strobe, launched and dropped on falling edges
  task automatic read(input int idx);
    @(negedge clk);
    rd[idx] = 1'b1;
    @(negedge clk);
    rd[idx] = 1'b0;
  endtask

  // Active bit may be written in any mode
  task automatic set_active(input logic v);
    @(negedge clk);
    wr_active_bit = 1'b1;
    wr_active_val = v;
    @(negedge clk);
    wr_active_bit = 1'b0;
  endtask

  // Plain write; callers use it in standby except to probe refusal
  task automatic write();
    @(negedge clk);
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the event status flag block.
// Assumes the host model drives read strobes; the checker is bound in.
`timescale 1ns/1ps

module testbench;
  localparam int PLEN = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic boot_mode_pin = 1'b0;
  logic wr_soft_reset = 1'b0;
  logic wr_buf_flush = 1'b0;
  logic hibernate_exit = 1'b0;
  logic [7:0] host_wr_addr = 8'h00;
  logic [7:0] host_wr_data = 8'h00;
  logic [7:0] int_route_two = 8'h20;
  logic [7:0] int_enable = 8'h00;
  logic [1:0] buf_mode = 2'h0;
  logic [3:0] ev = 4'h0;
  logic [4:0] lv = 5'h00;
  logic outside_latch_enable = 1'b1;
  logic within_latch_enable = 1'b0;
  logic endian_select_in = 1'b0;
  logic external_trigger_mode = 1'b0;
  logic [6:0] rd;
  logic host_wr, wr_active_bit, wr_active_val;
  logic rd_status, rd_vector_magnitude_out, rd_axis_out;
  logic rd_outside_event_source, rd_within_event_source;
  logic rd_orientation_status_reg, rd_system_mode_reg;
  logic new_result, new_orientation, sleep_wake_change, boot_finished;
  logic buffer_watermark_flag, buffer_overflow_flag, buffer_gate_error;
  logic outside_event_active, within_event_active;
  logic [7:0] interrupt_event_status;
  logic active_bit, soft_reset_pulse, buf_flush_pulse, cfg_write_en;
  logic endian_select, buffer_invalidate, volatile_reset;
  logic interrupt_pin_one, interrupt_pin_two;
  int miscompares = 0;
  int cmp_count = 0;
  int hi_cnt = 0;

  // ==========================================================
  // Strobe and level maps, clock, pulse width counter
  assign {rd_system_mode_reg, rd_orientation_status_reg, rd_within_event_source,
    rd_outside_event_source, rd_axis_out, rd_vector_magnitude_out,
    rd_status} = rd;
  assign {boot_finished, sleep_wake_change, new_orientation, new_result} = ev;
  assign {within_event_active, outside_event_active, buffer_gate_error,
    buffer_overflow_flag, buffer_watermark_flag} = lv;
  always #5 clk = ~clk;
  // Counted just after the edge so the pin register has settled
  always @(posedge clk) #1 if (interrupt_pin_one === 1'b1) hi_cnt++;

  aesf_flags #(.PULSE_LEN(PLEN)) dut (.*);
  aesf_host_model host (.*);

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_ev(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
  endtask
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_drdy();
    int_enable = 8'ha0;
    pulse_ev(0);
    tick(1);
    chk(interrupt_event_status, 8'h81);
    chk(8'(interrupt_pin_one), 8'h01);
    host.read(2);
    tick(1);
    chk(8'({interrupt_event_status[7], interrupt_pin_one}), 8'h00);
    pulse_ev(0);
    host.read(1);
    tick(1);
    chk(8'(interrupt_event_status[7]), 8'h00);
    // Data-ready routed to the second pin instead
    int_route_two = 8'ha0;
    pulse_ev(0);
    tick(1);
    chk(8'({interrupt_pin_two, interrupt_pin_one}), 8'h02);
    host.read(2);
    int_route_two = 8'h20;
  endtask

  task automatic t_ovf();
    pulse_ev(0);
    pulse_ev(0);
    tick(1);
    chk(8'(interrupt_event_status[6]), 8'h01);
    host.read(0);
    tick(1);
    chk(8'(interrupt_event_status[6]), 8'h00);
    host.read(2);
    pulse_ev(0);
    tick(1);
    chk(8'(interrupt_event_status[7:6]), 8'h02);
    buf_mode = 2'h1;
    pulse_ev(0);
    pulse_ev(0);
    tick(1);
    chk(8'(interrupt_event_status[7:6]), 8'h00);
    buf_mode = 2'h0;
  endtask

  task automatic t_buf();
    // Each source alone raises the event while the buffer is on
    for (int i = 0; i < 3; i++) begin
      lv = 5'(1 << i);
      buf_mode = 2'h1;
      tick(3);
      chk(8'({interrupt_event_status[5], interrupt_pin_two}), 8'h03);
    end
    lv = 5'h01;
    buf_mode = 2'h3;
    tick(3);
    chk(8'({interrupt_event_status[5], interrupt_pin_two}), 8'h00);
    lv = 5'h03;
    tick(3);
    chk(8'({interrupt_event_status[5], interrupt_pin_two}), 8'h03);
    buf_mode = 2'h0;
    tick(3);
    chk(8'(interrupt_event_status[5]), 8'h00);
    lv = 5'h00;
  endtask

  task automatic t_thr();
    lv = 5'h18;
    tick(1);
    lv = 5'h00;
    tick(3);
    chk(8'(interrupt_event_status[4:3]), 8'h02);
    host.read(3);
    tick(1);
    chk(8'(interrupt_event_status[4]), 8'h00);
    // Latch settings swapped: within holds, outside follows the event
    outside_latch_enable = 1'b0;
    within_latch_enable = 1'b1;
    lv = 5'h18;
    tick(1);
    lv = 5'h00;
    tick(3);
    chk(8'(interrupt_event_status[4:3]), 8'h01);
    host.read(4);
    tick(1);
    chk(8'(interrupt_event_status[3]), 8'h00);
  endtask

  task automatic t_misc();
    pulse_ev(1);
    pulse_ev(2);
    tick(1);
    chk(8'(interrupt_event_status[2:1]), 8'h03);
    host.read(5);
    host.read(6);
    tick(1);
    chk(8'(interrupt_event_status[2:1]), 8'h00);
    endian_select_in = 1'b1;
    host_wr_addr = 8'h15;
    host.write();
    tick(1);
    chk(8'(endian_select), 8'h01);
    external_trigger_mode = 1'b1;
    host.set_active(1'b1);
    endian_select_in = 1'b0;
    host.write();
    host.set_active(1'b0);
    tick(1);
    chk(8'({endian_select, active_bit}), 8'h03);
    external_trigger_mode = 1'b0;
    // Soft reset leaves trigger mode and drops the boot flag
    wr_soft_reset = 1'b1;
    #1;
    chk(8'(soft_reset_pulse), 8'h01);
    tick(1);
    wr_soft_reset = 1'b0;
    tick(1);
    chk(8'({interrupt_event_status[0], active_bit}), 8'h00);
    pulse_ev(3);
    tick(1);
    chk(8'(interrupt_event_status[0]), 8'h01);
    // Flush passes in standby; hibernate exit drops the boot flag
    hibernate_exit = 1'b1;
    wr_buf_flush = 1'b1;
    #1;
    chk(8'({soft_reset_pulse, buf_flush_pulse}), 8'h01);
    tick(1);
    hibernate_exit = 1'b0;
    wr_buf_flush = 1'b0;
    tick(1);
    chk(8'(interrupt_event_status[0]), 8'h00);
  endtask

  task automatic t_pulse();
    boot_mode_pin = 1'b1;
    tick(4);
    hi_cnt = 0;
    pulse_ev(0);
    host.read(2);
    tick(2 * PLEN);
    chk(8'(hi_cnt), 8'(PLEN));
    host.set_active(1'b1);
    hi_cnt = 0;
    pulse_ev(0);
    tick(3);
    host.set_active(1'b0);
    tick(2 * PLEN);
    chk(8'(hi_cnt < 8), 8'h01);
    boot_mode_pin = 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    tick(6);
    srst = 1'b0;
    tick(1);
    chk(interrupt_event_status, 8'h01);
    chk(8'({interrupt_pin_one, interrupt_pin_two, endian_select}), 8'h00);
    t_drdy();
    t_ovf();
    t_buf();
    t_thr();
    t_misc();
    t_pulse();
    end_sim();
  end
endmodule
